//--- src/dtcu_top.sv
// dual time base capture/compare array with apb register access
// assumes pins, count inputs and the timer-six pulse are synchronous to pclk
//
// Function
// - sixteen channels, one clock resolution
// - staggered option coarsens resolution to eight clocks
// - two 16-bit counters with reload registers
// - counter clock: prescaler or timer-six pulses
// - counters also count rising edges of their external input
// - each channel selects time base and function
// - one pin per channel, input or output
// - capture copies assigned time base on event
// - capture raises the channel interrupt request
// - capture edge: rising, falling or both
// - compare channels match continuously against time base
// - mode zero: interrupt only, repeatable
// - mode one: pin toggles on every match
// - mode two: interrupt once per period
// - mode three: set on match, clear on overflow
// - double register: two channels toggle one pin
// - single event option stops repeated events
// - timer-six pulses can clock either time base
// - per channel request, enable, priority; software set
`timescale 1ns/100ps
module dtcu_top #(
    parameter int NUM_CH = dtcu_pkg::NUM_CH
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NUM_CH-1:0] ch_in,
    output logic      [NUM_CH-1:0] ch_out,
    output logic      [NUM_CH-1:0] ch_oe_n,
    input  wire logic [1:0]        ext_count,
    input  wire logic              six_pulse,
    output logic      [NUM_CH-1:0] irq
);

    // ************************************************************
    // state
    // ************************************************************
    logic [15:0]             tmr_q   [2];
    logic [15:0]             rld_q   [2];
    dtcu_pkg::dtcu_tctl_type tctl_q  [2];
    logic [1:0]              fresh_q;
    logic                    stag_q;
    logic [2:0]              phase_q;
    logic [7:0]              pre_q;
    logic [1:0]              ext_prev_q;
    logic [NUM_CH-1:0]       in_prev_q;
    logic [15:0]             val_q   [NUM_CH];
    dtcu_pkg::dtcu_cctl_type cctl_q  [NUM_CH];
    dtcu_pkg::dtcu_ictl_type ictl_q  [NUM_CH];
    logic [NUM_CH-1:0]       done_q;
    logic [NUM_CH-1:0]       once_q;
    logic [31:0]             prdata_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic [NUM_CH-1:0]       out_q;
    logic [NUM_CH-1:0]       oe_n_q;
    logic [NUM_CH-1:0]       irq_q;

    logic [1:0]        tick;
    logic [1:0]        ovf;
    logic [NUM_CH-1:0] match;
    logic [NUM_CH-1:0] cap;
    logic [NUM_CH-1:0] pair_drv;
    logic [NUM_CH-1:0] pair_owned;
    logic [31:0]       rdata;
    logic              rerr;
    logic              wr_en;
    logic              rd_start;
    logic [3:0]        widx;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign ch_out  = out_q;
    assign ch_oe_n = oe_n_q;
    assign irq     = irq_q;

    // ************************************************************
    // apb slave
    // ************************************************************
    // one wait state: the answer is registered so prdata comes from a flop
    assign rd_start = psel && penable && !pready_q;
    assign wr_en    = psel && penable && pwrite && pready_q && !pslverr_q;
    assign widx     = paddr[5:2];

    always_comb begin
        rdata = 32'h0000_0000;
        rerr  = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            rerr = 1'b1;
        end else if (paddr[7:6] == dtcu_pkg::OFF_VAL[7:6]) begin
            rdata = {16'h0000, val_q[widx]};
        end else if (paddr[7:6] == dtcu_pkg::OFF_CCTL[7:6]) begin
            rdata = {24'h00_0000, cctl_q[widx]};
        end else if (paddr[7:6] == dtcu_pkg::OFF_ICTL[7:6]) begin
            rdata = {26'h000_0000, ictl_q[widx]};
        end else begin
            unique case (paddr)
                dtcu_pkg::OFF_TMR0: rdata = {16'h0000, tmr_q[0]};
                dtcu_pkg::OFF_RLD0: rdata = {16'h0000, rld_q[0]};
                dtcu_pkg::OFF_TMR1: rdata = {16'h0000, tmr_q[1]};
                dtcu_pkg::OFF_RLD1: rdata = {16'h0000, rld_q[1]};
                dtcu_pkg::OFF_TCTL: begin
                    rdata[dtcu_pkg::TCTL0_LSB +: 6] = tctl_q[0];
                    rdata[dtcu_pkg::TCTL1_LSB +: 6] = tctl_q[1];
                    rdata[dtcu_pkg::STAG_BIT]       = stag_q;
                end
                default:            rerr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= rd_start;
            pslverr_q <= rd_start && rerr;
            if (rd_start && !pwrite) begin
                prdata_q <= rdata;
            end
        end
    end

    // ************************************************************
    // time bases
    // ************************************************************
    always_comb begin
        logic [7:0] mask;
        mask = 8'h00;
        for (int t = 0; t < 2; t++) begin
            mask = 8'((16'h0001 << tctl_q[t].presc) - 16'h0001);
            unique case (tctl_q[t].src)
                dtcu_pkg::SRC_PRESC: tick[t] = (pre_q & mask) == mask;
                dtcu_pkg::SRC_SIX:   tick[t] = six_pulse;
                dtcu_pkg::SRC_EXT:   tick[t] = ext_count[t] && !ext_prev_q[t];
                dtcu_pkg::SRC_STOP:  tick[t] = 1'b0;
            endcase
            // staggered: counters step only on the last phase of eight
            tick[t] = tick[t] && tctl_q[t].run
                      && (!stag_q || phase_q == 3'(dtcu_pkg::STAGGER_CYCLES - 1));
            ovf[t]  = tick[t] && tmr_q[t] == dtcu_pkg::TMR_MAX;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q      <= 8'h00;
            phase_q    <= 3'h0;
            ext_prev_q <= 2'h0;
            fresh_q    <= 2'h0;
        end else begin
            pre_q      <= pre_q + 8'h01;
            phase_q    <= phase_q + 3'h1;
            ext_prev_q <= ext_count;
            for (int t = 0; t < 2; t++) begin
                // a new count value stays eligible for one clock, or one
                // full stagger round so each channel sees it in its slot
                fresh_q[t] <= tick[t] || (fresh_q[t] && stag_q
                              && phase_q != 3'(dtcu_pkg::STAGGER_CYCLES - 1));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int t = 0; t < 2; t++) begin
                tmr_q[t]  <= dtcu_pkg::RST_TMR;
                rld_q[t]  <= dtcu_pkg::RST_RLD;
                tctl_q[t] <= dtcu_pkg::RST_TCTL;
            end
            stag_q <= 1'b0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (ovf[t]) begin
                    tmr_q[t] <= rld_q[t];
                end else if (tick[t]) begin
                    tmr_q[t] <= tmr_q[t] + 16'h0001;
                end
            end
            if (wr_en) begin
                unique case (paddr)
                    dtcu_pkg::OFF_TMR0: tmr_q[0] <= pwdata[15:0];
                    dtcu_pkg::OFF_RLD0: rld_q[0] <= pwdata[15:0];
                    dtcu_pkg::OFF_TMR1: tmr_q[1] <= pwdata[15:0];
                    dtcu_pkg::OFF_RLD1: rld_q[1] <= pwdata[15:0];
                    dtcu_pkg::OFF_TCTL: begin
                        tctl_q[0] <= pwdata[dtcu_pkg::TCTL0_LSB +: 6];
                        tctl_q[1] <= pwdata[dtcu_pkg::TCTL1_LSB +: 6];
                        stag_q    <= pwdata[dtcu_pkg::STAG_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // channel events
    // ************************************************************
    always_comb begin
        for (int n = 0; n < NUM_CH; n++) begin
            logic t;
            logic cmp;
            logic lock;
            logic rise;
            logic fall;
            t    = cctl_q[n].tsel;
            cmp  = cctl_q[n].mode inside {dtcu_pkg::CH_CMP0, dtcu_pkg::CH_CMP1,
                                          dtcu_pkg::CH_CMP2, dtcu_pkg::CH_CMP3};
            lock = done_q[n] && cctl_q[n].mode inside {dtcu_pkg::CH_CMP2,
                                                       dtcu_pkg::CH_CMP3};
            match[n] = cmp && fresh_q[t] && tmr_q[t] == val_q[n] && !lock
                       && !once_q[n]
                       && (!stag_q || phase_q == 3'(n));
            rise   = ch_in[n] && !in_prev_q[n];
            fall   = !ch_in[n] && in_prev_q[n];
            cap[n] = cctl_q[n].mode == dtcu_pkg::CH_CAPTURE
                     && ((cctl_q[n].edge_sel[0] && rise)
                     || (cctl_q[n].edge_sel[1] && fall));
            pair_drv[n]   = (n < NUM_CH / 2) && cctl_q[n].dbl;
            pair_owned[n] = (n >= NUM_CH / 2) && cctl_q[(n + NUM_CH / 2) % NUM_CH].dbl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < NUM_CH; n++) begin
                val_q[n]  <= dtcu_pkg::RST_TMR;
                cctl_q[n] <= dtcu_pkg::RST_CCTL;
            end
            in_prev_q <= '0;
        end else begin
            in_prev_q <= ch_in;
            for (int n = 0; n < NUM_CH; n++) begin
                // capture beats a software write in the same clock
                if (cap[n]) begin
                    val_q[n] <= tmr_q[cctl_q[n].tsel];
                end else if (wr_en && paddr[7:6] == dtcu_pkg::OFF_VAL[7:6] && widx == 4'(n)) begin
                    val_q[n] <= pwdata[15:0];
                end
                if (wr_en && paddr[7:6] == dtcu_pkg::OFF_CCTL[7:6] && widx == 4'(n)) begin
                    cctl_q[n] <= pwdata[7:0];
                end
            end
        end
    end

    // period lock and single-event consumption
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= '0;
            once_q <= '0;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                if (match[n]) begin
                    done_q[n] <= 1'b1;
                end else if (ovf[cctl_q[n].tsel]) begin
                    done_q[n] <= 1'b0;
                end
                if (match[n] && cctl_q[n].single) begin
                    once_q[n] <= 1'b1;
                end else if (wr_en && paddr[7:6] == dtcu_pkg::OFF_CCTL[7:6] && widx == 4'(n)) begin
                    once_q[n] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    // the upper eight channels may feed the pin of their partner n-8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q  <= '0;
            oe_n_q <= '1;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                // pin is an output in modes one and three, or on a lower channel with dbl set, unless its partner owns it
                oe_n_q[n] <= !(!pair_owned[n] && (pair_drv[n] || cctl_q[n].mode inside
                             {dtcu_pkg::CH_CMP1, dtcu_pkg::CH_CMP3}));
                if (((cctl_q[n].mode == dtcu_pkg::CH_CMP1 || pair_drv[n]) && match[n])
                    || (pair_drv[n] && match[(n + NUM_CH / 2) % NUM_CH])) begin
                    out_q[n] <= !out_q[n];
                end else if (cctl_q[n].mode == dtcu_pkg::CH_CMP3 && match[n]) begin
                    out_q[n] <= 1'b1;
                end else if (cctl_q[n].mode == dtcu_pkg::CH_CMP3 && ovf[cctl_q[n].tsel]) begin
                    out_q[n] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // interrupt nodes
    // ************************************************************
    // hardware set wins over a software clear in the same clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < NUM_CH; n++) begin
                ictl_q[n] <= dtcu_pkg::RST_ICTL;
            end
            irq_q <= '0;
        end else begin
            for (int n = 0; n < NUM_CH; n++) begin
                if (wr_en && paddr[7:6] == dtcu_pkg::OFF_ICTL[7:6] && widx == 4'(n)) begin
                    ictl_q[n]     <= pwdata[5:0];
                    ictl_q[n].req <= pwdata[0] || match[n] || cap[n];
                end else if (match[n] || cap[n]) begin
                    ictl_q[n].req <= 1'b1;
                end
                irq_q[n] <= ictl_q[n].req && ictl_q[n].en;
            end
        end
    end

endmodule

//--- src/dtcu_pkg.sv
// constants and carrier types for the dual time base capture/compare array
// assumes a 32-bit apb slave with byte addresses in an 8-bit window
package dtcu_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int NUM_CH         = 16;
    localparam int NUM_TMR        = 2;
    localparam int STAGGER_CYCLES = 8;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_TMR0 = 8'h00;
    localparam logic [7:0] OFF_RLD0 = 8'h04;
    localparam logic [7:0] OFF_TMR1 = 8'h08;
    localparam logic [7:0] OFF_RLD1 = 8'h0C;
    localparam logic [7:0] OFF_TCTL = 8'h10;
    localparam logic [7:0] OFF_VAL  = 8'h40;
    localparam logic [7:0] OFF_CCTL = 8'h80;
    localparam logic [7:0] OFF_ICTL = 8'hC0;

    // timer control field positions
    localparam int TCTL0_LSB = 0;
    localparam int TCTL1_LSB = 8;
    localparam int STAG_BIT  = 16;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        CH_OFF,
        CH_CAPTURE,
        CH_CMP0,
        CH_CMP1,
        CH_CMP2,
        CH_CMP3
    } dtcu_mode_type;

    typedef enum logic [1:0] {
        SRC_PRESC,
        SRC_SIX,
        SRC_EXT,
        SRC_STOP
    } dtcu_src_type;

    typedef struct packed {
        logic          run;
        dtcu_src_type  src;
        logic [2:0]    presc;
    } dtcu_tctl_type;

    typedef struct packed {
        logic          dbl;
        logic          single;
        logic          tsel;
        logic [1:0]    edge_sel;
        dtcu_mode_type mode;
    } dtcu_cctl_type;

    typedef struct packed {
        logic [3:0] prio;
        logic       en;
        logic       req;
    } dtcu_ictl_type;

    // ************************************************************
    // reset values and counter maximum
    // ************************************************************
    localparam logic [15:0]   RST_TMR  = 16'h0000;
    localparam logic [15:0]   RST_RLD  = 16'h0000;
    localparam logic [15:0]   TMR_MAX  = 16'hFFFF;
    localparam dtcu_tctl_type RST_TCTL = '{run: 1'b0, src: SRC_PRESC, presc: 3'h0};
    localparam dtcu_cctl_type RST_CCTL = '{dbl: 1'b0, single: 1'b0, tsel: 1'b0,
                                           edge_sel: 2'h0, mode: CH_OFF};
    localparam dtcu_ictl_type RST_ICTL = '{prio: 4'h0, en: 1'b0, req: 1'b0};

endpackage

//--- bench/dtcu_top_properties.sv
// apb and pin-enable checks for the dual time base capture/compare array
// assumes the bind below attaches it to every dtcu_top instance
`timescale 1ns/100ps
module dtcu_top_check #(
    parameter int NUM_CH = dtcu_pkg::NUM_CH
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [NUM_CH-1:0] ch_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ************************************************************
    // register bus
    // ************************************************************
    ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    setup_quiet_a: assert property (psel && !penable |=> !pready)
        else $error("ready during setup");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    hole_refused_a: assert property (psel && penable && !pready
        && paddr inside {[8'h14:8'h3C]} |=> pslverr)
        else $error("unmapped address accepted");
    misalign_refused_a: assert property (psel && penable && !pready
        && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned address accepted");
    mapped_ok_a: assert property (psel && penable && !pready
        && paddr == dtcu_pkg::OFF_TCTL |=> !pslverr)
        else $error("mapped address refused");

    // ************************************************************
    // pins
    // ************************************************************
    // drive direction only follows channel setup, never traffic
    pin_dir_a: assert property ($changed(ch_oe_n) |-> $past(pready && pwrite, 2))
        else $error("pin direction changed without a write");
endmodule

bind dtcu_top dtcu_top_check #(.NUM_CH(NUM_CH)) i_check (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .ch_oe_n (ch_oe_n)
);

//--- bench/dtcu_pins.sv
// model of the channel pins outside the array
// assumes no pull on the pins; released pins show the bench level
`timescale 1ns/100ps
module dtcu_pins #(
    parameter int NUM_CH = dtcu_pkg::NUM_CH
) (
    input  wire logic [NUM_CH-1:0] ch_out,
    input  wire logic [NUM_CH-1:0] ch_oe_n,
    input  wire logic [NUM_CH-1:0] pin_drv,
    output logic      [NUM_CH-1:0] ch_in
);
    // driven pins read back the array's level
    assign ch_in = (ch_out & ~ch_oe_n) | (pin_drv & ch_oe_n);
endmodule

//--- bench/dtcu_top_bench.sv
// self-checking bench for the dual time base capture/compare array
// assumes dtcu_pkg, dtcu_top, dtcu_pins and the checker are compiled first
`timescale 1ns/100ps
module dtcu_top_bench;
    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] ch_in;
    logic [15:0] ch_out;
    logic [15:0] ch_oe_n;
    logic [15:0] pin_drv    = 16'h0000;
    logic [1:0]  ext_count  = 2'h0;
    logic        six_pulse  = 1'b0;
    logic [15:0] irq;
    logic [31:0] rd;
    logic        er;
    int          cyc        = 0;
    int          fail_count = 0;
    int          checks     = 0;

    always #5 pclk = ~pclk;

    dtcu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out),
        .ch_oe_n(ch_oe_n), .ext_count(ext_count), .six_pulse(six_pulse), .irq(irq));
    dtcu_pins i_pins (.ch_out(ch_out), .ch_oe_n(ch_oe_n), .pin_drv(pin_drv),
        .ch_in(ch_in));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task give_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer read mid-cycle, where it stands until the sampling edge
        do @(negedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task wait_pin(input int i, input logic lvl, output int t);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (ch_out[i] !== lvl && n < 100);
        chk(32'(ch_out[i]), 32'(lvl));
        t = cyc;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_reset;
        rdchk(dtcu_pkg::OFF_TCTL, 32'h0);
        rdchk(dtcu_pkg::OFF_CCTL + 8'h3C, 32'h0);
        rdchk(dtcu_pkg::OFF_ICTL, 32'h0);
        chk(32'(ch_oe_n), 32'h0000FFFF);
        chk(32'(irq), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, 8'h42, 32'h1);
        chk(32'(er), 32'h1);
    endtask

    task t_compare;
        int a;
        int b;
        wr(dtcu_pkg::OFF_RLD0, 32'h0000FFF0);
        wr(dtcu_pkg::OFF_TMR0, 32'h0000FFF0);
        wr(dtcu_pkg::OFF_VAL, 32'h0000FFF8);
        wr(dtcu_pkg::OFF_VAL + 8'h04, 32'h0000FFF4);
        wr(dtcu_pkg::OFF_CCTL, 32'h00000005);
        wr(dtcu_pkg::OFF_CCTL + 8'h04, 32'h00000003);
        wr(dtcu_pkg::OFF_ICTL, 32'h00000002);
        wr(dtcu_pkg::OFF_TCTL, 32'h00000020);
        chk(32'(ch_oe_n[1:0]), 32'h0);
        wait_pin(0, 1'b1, a);
        repeat (3) @(posedge pclk);
        chk(32'(irq[0]), 32'h1);
        wait_pin(0, 1'b0, b);
        wait_pin(0, 1'b1, b);
        // sixteen ticks from reload to overflow
        chk(b - a, 16);
        wait_pin(1, ~ch_out[1], a);
        wait_pin(1, ~ch_out[1], b);
        chk(b - a, 16);
    endtask

    task t_capture;
        wr(dtcu_pkg::OFF_CCTL + 8'h08, 32'h00000029);
        wr(dtcu_pkg::OFF_TCTL, 32'h00003020);
        repeat (5) begin
            @(posedge pclk);
            ext_count <= 2'h2;
            @(posedge pclk);
            ext_count <= 2'h0;
        end
        @(posedge pclk);
        pin_drv[2] <= 1'b1;
        repeat (3) @(posedge pclk);
        rdchk(dtcu_pkg::OFF_VAL + 8'h08, 32'h5);
        rdchk(dtcu_pkg::OFF_ICTL + 8'h08, 32'h1);
        wr(dtcu_pkg::OFF_ICTL + 8'h08, 32'h0);
        @(posedge pclk);
        ext_count <= 2'h2;
        @(posedge pclk);
        pin_drv[2] <= 1'b0;
        repeat (3) @(posedge pclk);
        rdchk(dtcu_pkg::OFF_VAL + 8'h08, 32'h5);
        rdchk(dtcu_pkg::OFF_ICTL + 8'h08, 32'h0);
        rdchk(dtcu_pkg::OFF_TMR1, 32'h6);
    endtask

    task t_six;
        wr(dtcu_pkg::OFF_TMR1, 32'h0);
        wr(dtcu_pkg::OFF_TCTL, 32'h00002820);
        repeat (3) begin
            @(posedge pclk);
            six_pulse <= 1'b1;
            @(posedge pclk);
            six_pulse <= 1'b0;
        end
        repeat (2) @(posedge pclk);
        rdchk(dtcu_pkg::OFF_TMR1, 32'h3);
        wr(dtcu_pkg::OFF_ICTL + 8'h0C, 32'h00000003);
        repeat (3) @(posedge pclk);
        chk(32'(irq[3]), 32'h1);
        wr(dtcu_pkg::OFF_ICTL + 8'h0C, 32'h00000002);
        repeat (3) @(posedge pclk);
        chk(32'(irq[3]), 32'h0);
    endtask

    task t_modes;
        wr(dtcu_pkg::OFF_TCTL, 32'h00002800);
        wr(dtcu_pkg::OFF_TMR0, 32'h0000FFF0);
        for (int n = 4; n < 8; n++) begin
            wr(dtcu_pkg::OFF_VAL + 8'(4 * n), 32'h0000FFF2);
        end
        wr(dtcu_pkg::OFF_VAL + 8'h3C, 32'h0000FFF5);
        wr(dtcu_pkg::OFF_CCTL + 8'h10, 32'h00000004);
        wr(dtcu_pkg::OFF_CCTL + 8'h14, 32'h00000042);
        wr(dtcu_pkg::OFF_CCTL + 8'h18, 32'h00000002);
        wr(dtcu_pkg::OFF_CCTL + 8'h1C, 32'h00000082);
        wr(dtcu_pkg::OFF_CCTL + 8'h3C, 32'h00000002);
        chk(32'(ch_oe_n[15:7]), 32'h000001FE);
        // first pass over the match values, stopped well before overflow
        wr(dtcu_pkg::OFF_TCTL, 32'h00002820);
        wr(dtcu_pkg::OFF_TCTL, 32'h00002800);
        chk(32'(ch_out[7]), 32'h1);
        rdchk(dtcu_pkg::OFF_ICTL + 8'h10, 32'h1);
        for (int n = 4; n < 7; n++) begin
            wr(dtcu_pkg::OFF_ICTL + 8'(4 * n), 32'h0);
        end
        // second pass in the same period: mode two and single event stay quiet
        wr(dtcu_pkg::OFF_TMR0, 32'h0000FFF0);
        wr(dtcu_pkg::OFF_TCTL, 32'h00002820);
        wr(dtcu_pkg::OFF_TCTL, 32'h00002800);
        chk(32'(ch_out[7]), 32'h0);
        rdchk(dtcu_pkg::OFF_ICTL + 8'h10, 32'h0);
        rdchk(dtcu_pkg::OFF_ICTL + 8'h14, 32'h0);
        rdchk(dtcu_pkg::OFF_ICTL + 8'h18, 32'h1);
        // third pass crosses an overflow, which frees mode two again
        wr(dtcu_pkg::OFF_TCTL, 32'h00002820);
        repeat (20) @(posedge pclk);
        wr(dtcu_pkg::OFF_TCTL, 32'h00002800);
        chk(32'(ch_out[7]), 32'h1);
        rdchk(dtcu_pkg::OFF_ICTL + 8'h10, 32'h1);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_compare;
        t_capture;
        t_six;
        t_modes;
        give_verdict;
    end
endmodule
